// [dv/test_bit_skip_and_call_exec.sv]
// Self-checking testbench for the bit-test-skip and call execute block.
`timescale 1ns/1ps
module test_bit_skip_and_call_exec;
    import bsc_pkg::*;

    typedef struct packed {
        logic [IW-1:0]  word;
        logic [PCW-1:0] pc;
        logic [7:0]     file;
        logic [7:0]     latch;
        logic           busy;
    } bsc_row_type;

    logic                clk = 1'b0;
    logic                rst;
    logic                q_tick;
    bsc_instr_type       instr;
    logic [7:0]          file_data;
    logic [7:0]          latch;
    logic [2:0]          flags;
    logic [FAW-1:0]      file_addr;
    logic                file_read;
    logic                file_write;
    bsc_flow_type        flow;
    logic                skip;
    logic                busy;
    logic [2:0]          flags_out;
    bsc_q_type           phase;
    int                  gap;
    int                  miscompares = 0;
    int                  checks_done = 0;

    bsc_row_type rows [9] = '{
        '{14'h1c05, 13'h0010, 8'h01, 8'h00, 1'b1}, '{14'h1fff, 13'h0011, 8'h7f, 8'h00, 1'b0},
        '{14'h1f80, 13'h0012, 8'h80, 8'hff, 1'b1}, '{14'h1daa, 13'h0013, 8'hf7, 8'h00, 1'b0},
        '{14'h27ff, 13'h1fff, 8'h00, 8'h18, 1'b1}, '{14'h2000, 13'h0123, 8'hff, 8'he7, 1'b1},
        '{14'h2555, 13'h0abc, 8'h00, 8'h10, 1'b1}, '{14'h3fff, 13'h0200, 8'hff, 8'hff, 1'b0},
        '{14'h2800, 13'h0201, 8'hff, 8'hff, 1'b0}};

    bsc_exec i_dut (
        .CLK_IN           (clk),
        .RST_IN           (rst),
        .Q_TICK_IN        (q_tick),
        .INSTR_IN         (instr),
        .FILE_DATA_IN     (file_data),
        .PC_HIGH_LATCH_IN (latch),
        .FLAGS_IN         (flags),
        .FILE_ADDR_OUT    (file_addr),
        .FILE_READ_OUT    (file_read),
        .FILE_WRITE_OUT   (file_write),
        .FLOW_OUT         (flow),
        .SKIP_OUT         (skip),
        .BUSY_OUT         (busy),
        .FLAGS_OUT        (flags_out),
        .PHASE_OUT        (phase)
    );

    always #2 clk = ~clk;

    // ****************************************************************
    // Helper tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // Advances by one Q tick; the tick is raised at the last falling edge, so the
    // outputs seen on return have stood for the whole gap between ticks.
    task automatic step();
        for (int i = 1; i <= gap; i++) begin
            @(negedge clk);
            q_tick = (i == gap);
        end
    endtask : step

    task automatic wait_q4();
        for (int k = 0; k < 40; k++) begin
            if (phase === Q4 && busy === 1'b0 && q_tick === 1'b1) return;
            step();
        end
        miscompares++;
        final_report();
    endtask : wait_q4

    task automatic run_row(input bsc_row_type r, input logic [2:0] f);
        logic           test_op;
        logic           call_op;
        logic           hit;
        logic [PCW-1:0] ret;
        test_op = (r.word[SKIP_OP_HI:SKIP_OP_LO] === OP_SKIP_SET);
        call_op = (r.word[CALL_OP_HI:CALL_OP_LO] === OP_CALL);
        hit     = test_op && r.file[r.word[BIT_HI:BIT_LO]];
        ret     = r.pc + PC_ONE;
        wait_q4();
        instr     = '{1'b1, r.word, r.pc};
        file_data = r.file;
        latch     = r.latch;
        flags     = f;
        step();
        instr.valid = 1'b0;
        chk(flags_out, f);
        step();
        chk(file_read, test_op);
        if (test_op) chk(file_addr, r.word[FILE_HI:FILE_LO]);
        chk(file_write, 1'b0);
        step();
        chk(skip, hit);
        step();
        chk({flow.push, flow.load}, {2{call_op}});
        if (call_op) begin
            chk(flow.ret_addr, ret);
            chk(flow.target, {r.latch[LATCH_HI:LATCH_LO], r.word[LIT_HI:0]});
        end
        step();
        chk(busy, r.busy);
        chk(flags_out, f);
    endtask : run_row

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst       = 1'b1;
        q_tick    = 1'b0;
        instr     = '0;
        file_data = 8'h00;
        latch     = 8'h00;
        flags     = 3'h0;
        gap       = 1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk({phase, flow.push, flow.load, busy, skip, file_read}, 7'h00);
        // Back-to-back ticks first, then spaced ticks to show outputs stand.
        for (int g = 1; g <= 3; g += 2) begin
            gap = g;
            foreach (rows[i]) run_row(rows[i], i[2:0]);
        end
        // Reset in the middle of a call must clear everything and recover.
        gap = 1;
        wait_q4();
        instr = '{1'b1, 14'h27ff, 13'h0001};
        step();
        step();
        rst = 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk({phase, flow.push, flow.load, busy, skip, file_read}, 7'h00);
        rst         = 1'b0;
        instr.valid = 1'b0;
        run_row(rows[4], 3'h5);
        final_report();
    end

endmodule : test_bit_skip_and_call_exec

// [hw/bsc_exec.sv]
// Decode and execute logic for the bit-test-skip-if-set and call instructions.
`timescale 1ns/1ps
module bsc_exec (
    input  wire logic                   CLK_IN,
    input  wire logic                   RST_IN,
    input  wire logic                   Q_TICK_IN,
    input  wire bsc_pkg::bsc_instr_type INSTR_IN,
    input  wire logic [7:0]             FILE_DATA_IN,
    input  wire logic [7:0]             PC_HIGH_LATCH_IN,
    input  wire logic [2:0]             FLAGS_IN,
    output logic [bsc_pkg::FAW-1:0]     FILE_ADDR_OUT,
    output logic                        FILE_READ_OUT,
    output logic                        FILE_WRITE_OUT,
    output bsc_pkg::bsc_flow_type       FLOW_OUT,
    output logic                        SKIP_OUT,
    output logic                        BUSY_OUT,
    output logic [2:0]                  FLAGS_OUT,
    output bsc_pkg::bsc_q_type          PHASE_OUT
);
    import bsc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        bsc_q_type               q;
        bsc_cyc_type             cyc;
        bsc_op_type              op;
        logic [IW-1:0]           word;
        logic [PCW-1:0]          pc;
        logic                    bit_val;
        logic [FAW-1:0]          faddr;
        logic                    fread;
        logic                    skip;
        bsc_flow_type            flow;
        logic [2:0]              flags;
    } bsc_state_type;

    bsc_state_type st;
    bsc_state_type next_st;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st       = st;
        next_st.flags = FLAGS_IN; // Flags pass through untouched.
        if (Q_TICK_IN) begin
            // Strobes stand for one whole Q phase, so they clear only on a tick.
            next_st.fread     = 1'b0;
            next_st.skip      = 1'b0;
            next_st.flow.push = 1'b0;
            next_st.flow.load = 1'b0;
            case (st.q)
                Q4: begin
                    next_st.q = Q1;
                    // Decode at the start of a new cycle.
                    if (st.cyc == ST_NOP || (st.op == OP_CALLI && st.cyc == ST_EXEC &&
                                             st.flow.load)) begin
                        next_st.cyc = ST_EXEC;
                        next_st.op  = OP_NONE;
                    end
                    if (st.cyc == ST_EXEC && st.op == OP_TEST && st.bit_val) begin
                        next_st.cyc = ST_NOP; // Fetched word replaced by a no-op.
                        next_st.op  = OP_NONE;
                    end else if (st.cyc == ST_EXEC && st.op == OP_CALLI) begin
                        next_st.cyc = ST_NOP; // Second call cycle does nothing.
                        next_st.op  = OP_NONE;
                    end else if (st.cyc == ST_EXEC) begin
                        next_st.op = OP_NONE;
                        if (INSTR_IN.valid &&
                            INSTR_IN.word[SKIP_OP_HI:SKIP_OP_LO] == OP_SKIP_SET) begin
                            next_st.op = OP_TEST;
                        end else if (INSTR_IN.valid &&
                                     INSTR_IN.word[CALL_OP_HI:CALL_OP_LO] == OP_CALL) begin
                            next_st.op = OP_CALLI;
                        end
                        next_st.word    = INSTR_IN.word;
                        next_st.pc      = INSTR_IN.pc;
                        next_st.bit_val = 1'b0;
                    end else begin
                        next_st.cyc = ST_EXEC;
                    end
                end
                Q1: begin
                    next_st.q = Q2;
                    if (st.op == OP_TEST) begin
                        next_st.faddr = st.word[FILE_HI:FILE_LO]; // Read in Q2.
                        next_st.fread = 1'b1;
                    end
                end
                Q2: begin
                    next_st.q = Q3;
                    if (st.op == OP_TEST) begin
                        next_st.bit_val = FILE_DATA_IN[st.word[BIT_HI:BIT_LO]];
                        next_st.skip    = FILE_DATA_IN[st.word[BIT_HI:BIT_LO]];
                    end
                end
                Q3: begin
                    next_st.q = Q4;
                    if (st.op == OP_CALLI) begin
                        // Return address pushed and PC written in Q4.
                        next_st.flow.push     = 1'b1;
                        next_st.flow.ret_addr = st.pc + PC_ONE;
                        next_st.flow.load     = 1'b1;
                        next_st.flow.target   = {PC_HIGH_LATCH_IN[LATCH_HI:LATCH_LO],
                                                 st.word[LIT_HI:0]};
                    end
                end
                default: next_st.q = Q1;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            st       <= '0;
            st.q     <= Q1;
            st.cyc   <= ST_EXEC;
            st.op    <= OP_NONE;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign FILE_ADDR_OUT  = st.faddr;
    assign FILE_READ_OUT  = st.fread;
    assign FILE_WRITE_OUT = 1'b0; // Neither instruction writes a file register.
    assign FLOW_OUT       = st.flow;
    assign SKIP_OUT       = st.skip;
    assign BUSY_OUT       = (st.cyc == ST_NOP);
    assign FLAGS_OUT      = st.flags;
    assign PHASE_OUT      = st.q;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_push_target;
        @(posedge CLK_IN) disable iff (RST_IN)
        st.flow.push |-> st.flow.load && st.flow.ret_addr == st.pc + PC_ONE;
    endproperty
    a_push_target: assert property (p_push_target) else $error("push without load");

    property p_target_low;
        @(posedge CLK_IN) disable iff (RST_IN)
        st.flow.load |-> st.flow.target[LIT_HI:0] == st.word[LIT_HI:0];
    endproperty
    a_target_low: assert property (p_target_low) else $error("bad target low");

    property p_target_high;
        @(posedge CLK_IN) disable iff (RST_IN)
        $rose(st.flow.load) |->
            st.flow.target[PC_UP_HI:PC_UP_LO] == $past(PC_HIGH_LATCH_IN[LATCH_HI:LATCH_LO]);
    endproperty
    a_target_high: assert property (p_target_high) else $error("bad target high");

    property p_load_q4;
        @(posedge CLK_IN) disable iff (RST_IN)
        st.flow.load |-> st.q == Q4 && st.op == OP_CALLI;
    endproperty
    a_load_q4: assert property (p_load_q4) else $error("PC written outside Q4");

    property p_read_q2;
        @(posedge CLK_IN) disable iff (RST_IN)
        st.fread |-> st.q == Q2 && st.op == OP_TEST;
    endproperty
    a_read_q2: assert property (p_read_q2) else $error("file read outside Q2");

    sequence s_skip_commit;
        st.op == OP_TEST && st.bit_val && st.q == Q4 && Q_TICK_IN;
    endsequence
    sequence s_nop_start;
        st.q == Q1 && st.cyc == ST_NOP && st.op == OP_NONE;
    endsequence
    property p_skip_nop;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_skip_commit |=> s_nop_start;
    endproperty
    a_skip_nop: assert property (p_skip_nop) else $error("skip without no-op");

    sequence s_call_commit;
        st.flow.load && Q_TICK_IN;
    endsequence
    property p_call_nop;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_call_commit |=> s_nop_start ##0 !st.flow.load;
    endproperty
    a_call_nop: assert property (p_call_nop) else $error("call not two cycles");

    property p_skip_q3;
        @(posedge CLK_IN) disable iff (RST_IN)
        st.skip |-> st.q == Q3 && st.op == OP_TEST && st.bit_val;
    endproperty
    a_skip_q3: assert property (p_skip_q3) else $error("skip outside Q3");

    property p_read_addr;
        @(posedge CLK_IN) disable iff (RST_IN)
        st.fread |-> st.faddr == st.word[FILE_HI:FILE_LO];
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("bad file address");

    property p_nop_quiet;
        @(posedge CLK_IN) disable iff (RST_IN)
        st.cyc == ST_NOP |-> !st.fread && !st.skip && !st.flow.push && !st.flow.load;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("no-op cycle active");

    sequence s_nop_end;
        st.cyc == ST_NOP && st.q == Q4 && Q_TICK_IN;
    endsequence
    property p_nop_one_cycle;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_nop_end |=> st.cyc == ST_EXEC && st.q == Q1;
    endproperty
    a_nop_one_cycle: assert property (p_nop_one_cycle) else $error("no-op too long");

    property p_clear_no_skip;
        @(posedge CLK_IN) disable iff (RST_IN)
        st.op == OP_TEST && st.q == Q4 && Q_TICK_IN && !st.bit_val |=> st.cyc == ST_EXEC;
    endproperty
    a_clear_no_skip: assert property (p_clear_no_skip) else $error("bad skip");

    property p_flags;
        @(posedge CLK_IN) disable iff (RST_IN)
        1'b1 |=> FLAGS_OUT == $past(FLAGS_IN);
    endproperty
    a_flags: assert property (p_flags) else $error("flags altered");

endmodule : bsc_exec

// [hw/bsc_pkg.sv]
// Package of constants and types for the bit-test-skip and call execute block.
// Overview of operation
// - Decode bit-test-skip-if-set; bit clear runs next instruction, one cycle.
// - Bit set discards fetched next instruction, executes a no-operation instead.
// - Test: Q1 decode, Q2 read file, Q3 test bit, Q4 no write.
// - Call pushes address of following instruction onto stack top first.
// - Call loads 11-bit literal into program counter bits 10 to 0.
// - Call fills program counter bits 12 and 11 from latch bits 4:3.
// - Decode call opcode 100 plus literal; two cycles, second does nothing.
// - Call cycle: decode, read literal, process, write PC and push in Q4.
package bsc_pkg;

    localparam int IW        = 14;
    localparam int PCW       = 13;
    localparam int LITW      = 11;
    localparam int FAW       = 7;
    localparam int BSW       = 3;

    // Opcode fields.
    localparam logic [3:0] OP_SKIP_SET = 4'h7;
    localparam logic [2:0] OP_CALL     = 3'h4;
    localparam int SKIP_OP_HI  = 13;
    localparam int SKIP_OP_LO  = 10;
    localparam int CALL_OP_HI  = 13;
    localparam int CALL_OP_LO  = 11;
    localparam int BIT_HI      = 9;
    localparam int BIT_LO      = 7;
    localparam int FILE_HI     = 6;
    localparam int FILE_LO     = 0;
    localparam int LIT_HI      = 10;
    localparam int LATCH_HI    = 4;
    localparam int LATCH_LO    = 3;
    localparam int PC_UP_HI    = 12;
    localparam int PC_UP_LO    = 11;

    localparam logic [PCW-1:0] PC_ONE   = 13'h0001;
    localparam logic [PCW-1:0] PC_RESET = 13'h0000;

    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} bsc_q_type;
    typedef enum {ST_EXEC, ST_NOP} bsc_cyc_type;
    typedef enum {OP_NONE, OP_TEST, OP_CALLI} bsc_op_type;

    typedef struct packed {
        logic           valid;
        logic [IW-1:0]  word;
        logic [PCW-1:0] pc;
    } bsc_instr_type;

    typedef struct packed {
        logic           push;
        logic [PCW-1:0] ret_addr;
        logic           load;
        logic [PCW-1:0] target;
    } bsc_flow_type;

endpackage : bsc_pkg
